// *** src/rsgem_pkg.sv ***
// Overview of operation
// R01: Only the parent slave answers group queries
// R02: Child executes queries to parent address too
// R03: Parent acts as in unicast, no setup
// R04: Group held in 0030h/0031h, -1 none, 1-31
// R05: Master writes both group words together, unicast
// R06: Group never saved; empty after power-up
// R07: Volatile error record, readable, cleared at power-up
// R08: Transmission error logs code 84h
// R09: Exception 01h/02h logs code 88h
// R10: Exception 04h logs 89h, 8Ah or 8Dh
// R11: Out-of-range exception logs code 8Ch
// R12: Alarm drops alarm output, stops motor, blinks
// R13: Warning output follows its cause
// R14: Rate switch 8 to F raises 83h
// R15: One 84h warns; good frame clears it
// R16: Consecutive 84h count reaching threshold alarms
// R17: Error threshold 1 to 10, initial 3
// R18: No valid frame within timeout alarms 85h
// R19: Timeout 0 disables, 1-10000 ms, initial 0
// R20: Reply after wait, silent, processing intervals
// R21: Outputs change within silent plus 4 ms
// R22: Configuration done within processing plus 1 s
// R23: Master waits for configuration completion
// R24: Stop time depends on stop-method input
// R25: Good frame clears consecutive error counter
package rsgem_pkg;
  localparam logic [15:0] GROUP_UPPER_ADDR = 16'h0030;
  localparam logic [15:0] GROUP_LOWER_ADDR = 16'h0031;
  localparam logic [31:0] GROUP_NONE       = 32'hFFFF_FFFF;
  localparam logic [4:0]  GROUP_MIN        = 5'h01;
  localparam logic [7:0]  CODE_SWITCH      = 8'h83;
  localparam logic [7:0]  CODE_TX_ERR      = 8'h84;
  localparam logic [7:0]  CODE_TIMEOUT     = 8'h85;
  localparam logic [7:0]  CODE_UNDEF       = 8'h88;
  localparam logic [7:0]  CODE_UIF_BUSY    = 8'h89;
  localparam logic [7:0]  CODE_NV_BUSY     = 8'h8A;
  localparam logic [7:0]  CODE_RANGE       = 8'h8C;
  localparam logic [7:0]  CODE_EXE_DIS     = 8'h8D;
  localparam logic [7:0]  EXC_ILL_FUNC     = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR     = 8'h02;
  localparam logic [7:0]  EXC_ILL_VALUE    = 8'h03;
  localparam logic [7:0]  EXC_DEV_FAIL     = 8'h04;
  localparam logic [3:0]  ERR_LIMIT_MIN    = 4'h1;
  localparam logic [3:0]  ERR_LIMIT_MAX    = 4'hA;
  localparam logic [3:0]  ERR_LIMIT_RST    = 4'h3;
  localparam logic [13:0] TIMEOUT_MAX_MS   = 14'h2710;
  localparam logic [13:0] TIMEOUT_RST_MS   = 14'h0000;
  localparam logic [3:0]  RATE_BAD_MIN     = 4'h8;
  localparam int          CLK_HZ           = 20000000;
  localparam int          MS_CYCLES        = CLK_HZ / 1000;
  localparam int          OUT_LIMIT_MS     = 4;
  localparam int          CFG_LIMIT_MS     = 1000;
  localparam int          BLINK_MS         = 250;
  localparam logic [14:0] MS_CYC_M1        = 15'(MS_CYCLES - 1);
  localparam logic [9:0]  BLINK_MS_M1      = 10'(BLINK_MS - 1);
  localparam logic [4:0]  LOG_DEPTH        = 5'h10;
  typedef enum logic [2:0] {
    RSGEM_EX_NONE, RSGEM_EX_UIF, RSGEM_EX_NV, RSGEM_EX_DIS, RSGEM_EX_RANGE
  } rsgem_cause_t;
endpackage : rsgem_pkg

// *** src/rsgem_ms_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsgem_ms_tick (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  import rsgem_pkg::*;
  typedef struct packed {
    logic [14:0] cnt;
    logic        tick;
  } rsgem_tick_t;
  rsgem_tick_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = (s_q.cnt == MS_CYC_M1);
    s_d.cnt  = s_d.tick ? 15'h0000 : s_q.cnt + 15'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick_o = s_q.tick;
endmodule // rsgem_ms_tick
`default_nettype wire

// *** src/rsgem_err_log.sv ***
`timescale 1ns/1ps
`default_nettype none
// Ring of error codes; newest overwrites oldest so logging never stalls
module rsgem_err_log #(
  parameter int DEPTH = 16
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] code_i,
  input  wire logic [3:0] rd_idx_i,
  output logic [7:0]      rd_code_o,
  output logic [4:0]      count_o
);
  import rsgem_pkg::*;
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [3:0]            wp;
    logic [4:0]            cnt;
    logic [7:0]            rd;
  } rsgem_log_t;
  rsgem_log_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (wr_i) begin
      s_d.mem[s_q.wp] = code_i; // [R07]
      s_d.wp = s_q.wp + 4'h1;
      if (s_q.cnt != LOG_DEPTH) begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end
    // Index 0 is the newest entry
    s_d.rd = s_q.mem[s_q.wp - 4'h1 - rd_idx_i];
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0; // [R07]
    end else begin
      s_q <= s_d;
    end
  end
  assign rd_code_o = s_q.rd;
  assign count_o   = s_q.cnt;
endmodule // rsgem_err_log
`default_nettype wire

// *** src/rsgem_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsgem_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [4:0]  OWN_ADDR_I,
  input  wire logic [3:0]  RATE_SELECT_SWITCH_I,
  input  wire logic        FRAME_DONE_I,
  input  wire logic        FRAME_ERR_I,
  input  wire logic [7:0]  FRAME_ADDR_I,
  input  wire logic        FRAME_IS_CFG_I,
  input  wire logic        FRAME_IS_OUT_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  input  wire logic [15:0] REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        EXC_VALID_I,
  input  wire logic [7:0]  EXC_CODE_I,
  input  wire rsgem_pkg::rsgem_cause_t EXC_CAUSE_I,
  input  wire logic [3:0]  ERR_LIMIT_I,
  input  wire logic [13:0] TIMEOUT_MS_I,
  input  wire logic        PROC_DONE_I,
  input  wire logic        STOP_METHOD_I,
  input  wire logic        TX_DONE_I,
  input  wire logic [3:0]  LOG_IDX_I,
  output logic             ACCEPT_O,
  output logic             RESPOND_O,
  output logic             REPLY_START_O,
  output logic [31:0]      REG_RDATA_O,
  output logic [7:0]       LOG_CODE_O,
  output logic [4:0]       LOG_COUNT_O,
  output logic [7:0]       ALARM_CODE_O,
  output logic             ALARM_OUTPUT_ONE_O,
  output logic             MOTOR_RUN_EN_O,
  output logic             STOP_DECEL_O,
  output logic             ALARM_INDICATOR_O,
  output logic             WARNING_OUTPUT_O,
  output logic             APPLY_OUT_O,
  output logic             CFG_BUSY_O,
  output logic             TIMING_FAULT_O
);
  import rsgem_pkg::*;
  typedef struct packed {
    logic [31:0] group;
    logic [7:0]  rate_m;
    logic [3:0]  rate_q;
    logic [3:0]  err_run;
    logic        warn;
    logic        alarm;
    logic [7:0]  alarm_code;
    logic [13:0] idle_ms;
    logic [9:0]  blink_ms;
    logic        blink;
    logic        reply_pend;
    logic        reply;
    logic        out_pend;
    logic [2:0]  out_ms;
    logic        cfg_busy;
    logic [9:0]  cfg_ms;
    logic        fault;
    logic        accept;
    logic        respond;
    logic [31:0] rdata;
  } rsgem_state_t;
  rsgem_state_t s_q, s_d;
  logic       ms_tick;
  logic       log_wr;
  logic [7:0] log_code;
  logic       grp_valid;
  logic       own_hit;
  logic       grp_hit;
  logic [3:0] err_lim;
  logic       good_frame;
  logic       bad_frame;
  logic       rate_bad;

  rsgem_ms_tick u_tick (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .tick_o  (ms_tick)
  );

  rsgem_err_log #(.DEPTH(16)) u_log (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .wr_i      (log_wr),
    .code_i    (log_code),
    .rd_idx_i  (LOG_IDX_I),
    .rd_code_o (LOG_CODE_O),
    .count_o   (LOG_COUNT_O)
  );

  always_comb begin
    // Only 1..31 in the low word with a zero high word is a valid group
    grp_valid = (s_q.group[31:5] == 27'h0) && (s_q.group[4:0] >= GROUP_MIN); // [R04]
    own_hit   = (FRAME_ADDR_I == {3'h0, OWN_ADDR_I}); // [R03]
    grp_hit   = grp_valid && (FRAME_ADDR_I == s_q.group[7:0]); // [R02]
    good_frame = FRAME_DONE_I && !FRAME_ERR_I && (own_hit || grp_hit);
    bad_frame  = FRAME_DONE_I && FRAME_ERR_I;
    rate_bad   = (s_q.rate_q >= RATE_BAD_MIN); // [R14]
    // Out-of-range threshold falls back to the initial value
    if (ERR_LIMIT_I < ERR_LIMIT_MIN || ERR_LIMIT_I > ERR_LIMIT_MAX) begin
      err_lim = ERR_LIMIT_RST; // [R17]
    end else begin
      err_lim = ERR_LIMIT_I;
    end
    log_wr   = 1'b0;
    log_code = 8'h00;
    if (bad_frame) begin
      log_wr   = 1'b1;
      log_code = CODE_TX_ERR; // [R08]
    end else if (EXC_VALID_I) begin
      log_wr = 1'b1;
      if (EXC_CODE_I == EXC_ILL_FUNC || EXC_CODE_I == EXC_ILL_ADDR) begin
        log_code = CODE_UNDEF; // [R09]
      end else if (EXC_CAUSE_I == RSGEM_EX_RANGE &&
                   (EXC_CODE_I == EXC_ILL_VALUE || EXC_CODE_I == EXC_DEV_FAIL)) begin
        log_code = CODE_RANGE; // [R11]
      end else if (EXC_CODE_I == EXC_DEV_FAIL && EXC_CAUSE_I == RSGEM_EX_UIF) begin
        log_code = CODE_UIF_BUSY; // [R10]
      end else if (EXC_CODE_I == EXC_DEV_FAIL && EXC_CAUSE_I == RSGEM_EX_NV) begin
        log_code = CODE_NV_BUSY; // [R10]
      end else if (EXC_CODE_I == EXC_DEV_FAIL && EXC_CAUSE_I == RSGEM_EX_DIS) begin
        log_code = CODE_EXE_DIS; // [R10]
      end else begin
        log_wr = 1'b0;
      end
    end

    s_d = s_q;
    // Switch is a pin; three flops before use, then sampled as a level
    s_d.rate_m = {s_q.rate_m[3:0], RATE_SELECT_SWITCH_I};
    s_d.rate_q = s_q.rate_m[7:4];
    s_d.accept  = good_frame; // [R02]
    // Children stay silent on group traffic
    s_d.respond = FRAME_DONE_I && !FRAME_ERR_I && own_hit; // [R01]

    if (REG_WR_I && REG_ADDR_I == GROUP_UPPER_ADDR) begin
      s_d.group = REG_WDATA_I; // [R05]
    end
    s_d.rdata = 32'h0000_0000;
    if (REG_RD_I && (REG_ADDR_I == GROUP_UPPER_ADDR || REG_ADDR_I == GROUP_LOWER_ADDR)) begin
      s_d.rdata = s_q.group; // [R05]
    end

    if (good_frame) begin
      s_d.err_run = 4'h0; // [R25]
      s_d.warn    = 1'b0; // [R15]
      s_d.idle_ms = 14'h0000;
    end else if (bad_frame) begin
      s_d.warn = 1'b1; // [R15]
      if (s_q.err_run + 4'h1 >= err_lim) begin
        s_d.alarm = 1'b1; // [R16]
        if (!s_q.alarm) begin
          s_d.alarm_code = CODE_TX_ERR;
        end
      end
      if (s_q.err_run != 4'hF) begin
        s_d.err_run = s_q.err_run + 4'h1;
      end
    end else if (ms_tick && TIMEOUT_MS_I != TIMEOUT_RST_MS) begin // [R19]
      if (s_q.idle_ms != TIMEOUT_MAX_MS) begin
        s_d.idle_ms = s_q.idle_ms + 14'h0001;
      end
      if (s_q.idle_ms + 14'h0001 >= TIMEOUT_MS_I) begin
        s_d.alarm = 1'b1; // [R18]
        if (!s_q.alarm) begin
          s_d.alarm_code = CODE_TIMEOUT;
        end
      end
    end
    if (rate_bad) begin
      s_d.alarm = 1'b1; // [R14]
      if (!s_q.alarm) begin
        s_d.alarm_code = CODE_SWITCH;
      end
    end

    if (s_q.alarm && ms_tick) begin
      if (s_q.blink_ms == BLINK_MS_M1) begin
        s_d.blink_ms = 10'h000;
        s_d.blink    = !s_q.blink; // [R12]
      end else begin
        s_d.blink_ms = s_q.blink_ms + 10'h001;
      end
    end

    // Reply launches once the upstream timers report all three intervals passed
    s_d.reply = 1'b0;
    if (s_q.respond) begin
      s_d.reply_pend = 1'b1;
    end
    if (s_q.reply_pend && TX_DONE_I) begin
      s_d.reply_pend = 1'b0;
      s_d.reply      = 1'b1; // [R20]
    end

    if (good_frame && FRAME_IS_OUT_I) begin
      s_d.out_pend = 1'b1;
      s_d.out_ms   = 3'h0;
    end else if (s_q.out_pend && ms_tick) begin
      s_d.out_ms = s_q.out_ms + 3'h1;
    end
    if (s_q.out_pend && (PROC_DONE_I || s_q.out_ms == 3'(OUT_LIMIT_MS))) begin
      s_d.out_pend = 1'b0; // [R21]
      if (!PROC_DONE_I) begin
        s_d.fault = 1'b1;
      end
    end

    if (good_frame && FRAME_IS_CFG_I) begin
      s_d.cfg_busy = 1'b1; // [R23]
      s_d.cfg_ms   = 10'h000;
    end else if (s_q.cfg_busy && ms_tick && s_q.cfg_ms != 10'h3FF) begin
      s_d.cfg_ms = s_q.cfg_ms + 10'h001;
    end
    if (s_q.cfg_busy && PROC_DONE_I) begin
      s_d.cfg_busy = 1'b0; // [R22]
    end else if (s_q.cfg_busy && s_q.cfg_ms == 10'(CFG_LIMIT_MS - 1) && ms_tick) begin
      s_d.cfg_busy = 1'b0; // [R22]
      s_d.fault    = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s_q       <= '0;
      s_q.group <= GROUP_NONE; // [R06]
    end else begin
      s_q <= s_d;
    end
  end

  assign ACCEPT_O           = s_q.accept;
  assign RESPOND_O          = s_q.respond;
  assign REPLY_START_O      = s_q.reply;
  assign REG_RDATA_O        = s_q.rdata;
  assign ALARM_CODE_O       = s_q.alarm_code;
  assign ALARM_OUTPUT_ONE_O = !s_q.alarm; // [R12]
  assign MOTOR_RUN_EN_O     = !s_q.alarm; // [R12]
  assign STOP_DECEL_O       = STOP_METHOD_I; // [R24]
  assign ALARM_INDICATOR_O  = s_q.alarm && !s_q.blink; // [R12]
  assign WARNING_OUTPUT_O   = s_q.warn; // [R13]
  assign APPLY_OUT_O        = s_q.out_pend;
  assign CFG_BUSY_O         = s_q.cfg_busy;
  assign TIMING_FAULT_O     = s_q.fault;
endmodule // rsgem_top
`default_nettype wire

// *** testbench/rsgem_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsgem_checker (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic [4:0]  OWN_ADDR_I,
  input wire logic        FRAME_DONE_I,
  input wire logic        FRAME_ERR_I,
  input wire logic [7:0]  FRAME_ADDR_I,
  input wire logic        REG_RD_I,
  input wire logic        STOP_METHOD_I,
  input wire logic        TX_DONE_I,
  input wire logic        ACCEPT_O,
  input wire logic        RESPOND_O,
  input wire logic        REPLY_START_O,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic        ALARM_OUTPUT_ONE_O,
  input wire logic        MOTOR_RUN_EN_O,
  input wire logic        ALARM_INDICATOR_O,
  input wire logic        WARNING_OUTPUT_O,
  input wire logic        STOP_DECEL_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_own_accept:
    assert property (FRAME_DONE_I && !FRAME_ERR_I && FRAME_ADDR_I == {3'h0, OWN_ADDR_I}
      |=> ACCEPT_O && RESPOND_O) else $error("own frame not answered");
  chk_bad_frame:
    assert property (FRAME_DONE_I && FRAME_ERR_I |=> !ACCEPT_O && WARNING_OUTPUT_O)
      else $error("bad frame handling wrong");
  chk_parent_only:
    assert property (RESPOND_O |-> ACCEPT_O && $past(FRAME_DONE_I)
      && $past(FRAME_ADDR_I) == {3'h0, $past(OWN_ADDR_I)}) else $error("child answered");
  chk_warn_clear:
    assert property (WARNING_OUTPUT_O && FRAME_DONE_I && !FRAME_ERR_I |=> !WARNING_OUTPUT_O)
      else $error("warning not cleared");
  chk_warn_cause:
    assert property ($rose(WARNING_OUTPUT_O) |-> $past(FRAME_DONE_I) && $past(FRAME_ERR_I))
      else $error("warning without error");
  chk_alarm_pins:
    assert property (MOTOR_RUN_EN_O == ALARM_OUTPUT_ONE_O
      && (!ALARM_OUTPUT_ONE_O || !ALARM_INDICATOR_O)) else $error("alarm pins disagree");
  chk_alarm_hold:
    assert property (!ALARM_OUTPUT_ONE_O |=> !ALARM_OUTPUT_ONE_O) else $error("alarm dropped");
  chk_reply_cause:
    assert property (REPLY_START_O |-> $past(TX_DONE_I)) else $error("early reply");
  chk_rdata_idle:
    assert property (!REG_RD_I |=> REG_RDATA_O == 32'h0) else $error("read data not idle");
  chk_stop_method:
    assert property (STOP_DECEL_O == STOP_METHOD_I) else $error("stop method lost");
  cov_group_hit: cover property (ACCEPT_O && !RESPOND_O);
  cov_warning: cover property ($rose(WARNING_OUTPUT_O));
  cov_alarm: cover property ($fell(ALARM_OUTPUT_ONE_O));
endmodule // rsgem_checker
bind rsgem_top rsgem_checker i_chk (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .OWN_ADDR_I(OWN_ADDR_I), .FRAME_DONE_I(FRAME_DONE_I),
  .FRAME_ERR_I(FRAME_ERR_I), .FRAME_ADDR_I(FRAME_ADDR_I), .REG_RD_I(REG_RD_I),
  .STOP_METHOD_I(STOP_METHOD_I), .TX_DONE_I(TX_DONE_I), .ACCEPT_O(ACCEPT_O),
  .RESPOND_O(RESPOND_O), .REPLY_START_O(REPLY_START_O), .REG_RDATA_O(REG_RDATA_O),
  .ALARM_OUTPUT_ONE_O(ALARM_OUTPUT_ONE_O), .MOTOR_RUN_EN_O(MOTOR_RUN_EN_O),
  .ALARM_INDICATOR_O(ALARM_INDICATOR_O), .WARNING_OUTPUT_O(WARNING_OUTPUT_O),
  .STOP_DECEL_O(STOP_DECEL_O)
);
`default_nettype wire

// *** testbench/rsgem_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsgem_master
  import rsgem_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        cfg_busy_i,
  input  wire logic [31:0] rdata_i,
  output logic             done_o,
  output logic             err_o,
  output logic [7:0]       addr_o,
  output logic             cfg_o,
  output logic             out_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic [15:0]      reg_addr_o,
  output logic [31:0]      wdata_o
);
  initial begin
    {done_o, err_o, cfg_o, out_o, wr_o, rd_o} = 6'h00;
    {addr_o, reg_addr_o, wdata_o} = 56'h0;
  end
  task automatic send(input logic [7:0] a, input logic e, input logic c, input logic o);
    while (cfg_busy_i) @(negedge clk_i);
    @(negedge clk_i);
    {done_o, err_o, cfg_o, out_o, addr_o} = {1'b1, e, c, o, a};
    @(negedge clk_i);
    {done_o, err_o, cfg_o, out_o} = 4'h0;
    addr_o = ~a; // Released line shows junk, not the old address
  endtask
  // Both group words always travel as one 32-bit access
  task automatic write_group(input logic [31:0] v);
    @(negedge clk_i);
    {wr_o, reg_addr_o, wdata_o} = {1'b1, GROUP_UPPER_ADDR, v};
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~v;
  endtask
  task automatic read_reg(input logic [15:0] a, output logic [31:0] v);
    @(negedge clk_i);
    {rd_o, reg_addr_o} = {1'b1, a};
    @(negedge clk_i);
    rd_o = 1'b0;
    v = rdata_i;
  endtask
endmodule // rsgem_master
`default_nettype wire

// *** testbench/rsgem_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsgem_top_tb;
  import rsgem_pkg::*;
  logic clk, rst_n, f_done, f_err, f_cfg, f_out, wr, rd, exc_v, proc_done, stop_m, tx_done;
  logic acc, resp, rstart, aone, run, sdec, aind, warn, apply, busy, tfault;
  logic [3:0] rate, lim, lidx;
  logic [4:0] own, lcount;
  logic [7:0] f_addr, exc_code, lcode, acode;
  logic [13:0] tmo;
  logic [15:0] raddr;
  logic [31:0] wdata, rdata, v;
  rsgem_cause_t cause;
  int failures, n_compared, n;
  logic [7:0] xcode [7] = '{EXC_ILL_FUNC, EXC_ILL_ADDR, EXC_ILL_VALUE, EXC_DEV_FAIL,
    EXC_DEV_FAIL, EXC_DEV_FAIL, EXC_DEV_FAIL};
  rsgem_cause_t xcause [7] = '{RSGEM_EX_NONE, RSGEM_EX_NONE, RSGEM_EX_RANGE, RSGEM_EX_UIF,
    RSGEM_EX_NV, RSGEM_EX_DIS, RSGEM_EX_RANGE};
  logic [7:0] xexp [7] = '{CODE_UNDEF, CODE_UNDEF, CODE_RANGE, CODE_UIF_BUSY, CODE_NV_BUSY,
    CODE_EXE_DIS, CODE_RANGE};
  rsgem_top i_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .OWN_ADDR_I(own), .RATE_SELECT_SWITCH_I(rate),
    .FRAME_DONE_I(f_done), .FRAME_ERR_I(f_err), .FRAME_ADDR_I(f_addr), .FRAME_IS_CFG_I(f_cfg),
    .FRAME_IS_OUT_I(f_out), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(raddr),
    .REG_WDATA_I(wdata), .EXC_VALID_I(exc_v), .EXC_CODE_I(exc_code), .EXC_CAUSE_I(cause),
    .ERR_LIMIT_I(lim), .TIMEOUT_MS_I(tmo), .PROC_DONE_I(proc_done), .STOP_METHOD_I(stop_m),
    .TX_DONE_I(tx_done), .LOG_IDX_I(lidx), .ACCEPT_O(acc), .RESPOND_O(resp),
    .REPLY_START_O(rstart), .REG_RDATA_O(rdata), .LOG_CODE_O(lcode), .LOG_COUNT_O(lcount),
    .ALARM_CODE_O(acode), .ALARM_OUTPUT_ONE_O(aone), .MOTOR_RUN_EN_O(run),
    .STOP_DECEL_O(sdec), .ALARM_INDICATOR_O(aind), .WARNING_OUTPUT_O(warn),
    .APPLY_OUT_O(apply), .CFG_BUSY_O(busy), .TIMING_FAULT_O(tfault)
  );
  rsgem_master i_mst (
    .clk_i(clk), .cfg_busy_i(busy), .rdata_i(rdata), .done_o(f_done), .err_o(f_err),
    .addr_o(f_addr), .cfg_o(f_cfg), .out_o(f_out), .wr_o(wr), .rd_o(rd),
    .reg_addr_o(raddr), .wdata_o(wdata)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] sw, input logic [3:0] l, input logic [13:0] t);
    @(negedge clk);
    {rst_n, rate, lim, tmo} = {1'b0, sw, l, t};
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
  endtask
  // Gap lets the reply become pending before the intervals elapse
  task automatic pulse_tx();
    repeat (2) @(negedge clk);
    tx_done = 1'b1;
    @(negedge clk);
    tx_done = 1'b0;
  endtask
  task automatic raise(input logic [7:0] c, input rsgem_cause_t k, input logic [7:0] exp);
    @(negedge clk);
    {exc_v, exc_code, cause} = {1'b1, c, k};
    @(negedge clk);
    exc_v = 1'b0;
    repeat (2) @(negedge clk);
    check("log code", {24'h0, lcode}, {24'h0, exp});
  endtask
  initial begin
    {rst_n, exc_v, proc_done, stop_m, tx_done, lidx, exc_code} = 16'h0;
    {own, cause, rate, lim, tmo} = {5'h03, RSGEM_EX_NONE, 4'h0, ERR_LIMIT_RST, 14'h0};
    {failures, n_compared} = 0;
    do_reset(4'h0, ERR_LIMIT_RST, 14'h0);
    i_mst.read_reg(GROUP_UPPER_ADDR, v);
    check("group at reset", v, GROUP_NONE);
    check("log count", {27'h0, lcount}, 32'h0);
    check("alarm out", {31'h0, aone && run}, 32'h1);
    i_mst.read_reg(16'h0032, v);
    check("unmapped read", v, 32'h0);
    i_mst.send(8'h05, 1'b0, 1'b0, 1'b0);
    check("no group accept", {31'h0, acc}, 32'h0);
    i_mst.write_group(32'h0000_0005);
    i_mst.read_reg(GROUP_LOWER_ADDR, v);
    check("group read", v, 32'h0000_0005);
    i_mst.send(8'h05, 1'b0, 1'b0, 1'b0);
    check("child accept", {30'h0, acc, resp}, 32'h2);
    pulse_tx();
    check("child silent", {31'h0, rstart}, 32'h0);
    i_mst.send(8'h03, 1'b0, 1'b0, 1'b0);
    check("own accept", {30'h0, acc, resp}, 32'h3);
    pulse_tx();
    check("reply start", {31'h0, rstart}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      i_mst.write_group(i == 0 ? 32'h0001_0005 : 32'h0000_0020);
      i_mst.send(i == 0 ? 8'h05 : 8'h20, 1'b0, 1'b0, 1'b0);
      check("bad group", {31'h0, acc}, 32'h0);
    end
    $display("Group test done");
    do_reset(4'h0, 4'h2, 14'h0);
    i_mst.read_reg(GROUP_UPPER_ADDR, v);
    check("group cleared", v, GROUP_NONE);
    for (int i = 0; i < 4; i++) begin
      i_mst.send(i[0] ? 8'h03 : 8'h09, ~i[0], 1'b0, 1'b0);
      check("warning", {31'h0, warn}, {31'h0, ~i[0]});
      check("bad not accepted", {31'h0, acc}, {31'h0, i[0]});
    end
    i_mst.send(8'h03, 1'b1, 1'b0, 1'b0);
    check("alarm after gaps", {31'h0, aone}, 32'h1);
    i_mst.send(8'h03, 1'b1, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    check("log 84", {24'h0, lcode}, {24'h0, CODE_TX_ERR});
    check("error alarm", {30'h0, aone, run}, 32'h0);
    check("alarm code", {24'h0, acode}, {24'h0, CODE_TX_ERR});
    for (int i = 0; i < 7; i++) begin
      raise(xcode[i], xcause[i], xexp[i]);
    end
    lidx = 4'h1;
    repeat (2) @(negedge clk);
    check("older log", {24'h0, lcode}, {24'h0, CODE_EXE_DIS});
    check("log count", {27'h0, lcount}, 32'd11);
    $display("Error test done");
    do_reset(4'h0, ERR_LIMIT_RST, 14'h0);
    i_mst.send(8'h03, 1'b0, 1'b1, 1'b0);
    @(negedge clk);
    check("cfg busy", {31'h0, busy}, 32'h1);
    proc_done = 1'b1;
    @(negedge clk);
    proc_done = 1'b0;
    repeat (2) @(negedge clk);
    check("cfg done", {30'h0, busy, tfault}, 32'h0);
    i_mst.send(8'h03, 1'b0, 1'b0, 1'b1);
    @(negedge clk);
    check("apply out", {31'h0, apply}, 32'h1);
    stop_m = 1'b1;
    @(negedge clk);
    check("stop method", {31'h0, sdec}, 32'h1);
    do_reset(4'h8, ERR_LIMIT_RST, 14'h0);
    repeat (6) @(negedge clk);
    check("switch alarm", {24'h0, acode}, {24'h0, CODE_SWITCH});
    check("switch pins", {30'h0, aone, run}, 32'h0);
    check("alarm lamp", {31'h0, aind}, 32'h1);
    do_reset(4'h0, ERR_LIMIT_RST, 14'h0001);
    for (n = 0; n < 3 * MS_CYCLES && aone; n++) @(negedge clk);
    check("timeout code", {24'h0, acode}, {24'h0, CODE_TIMEOUT});
    $display("Timing test done");
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule // rsgem_top_tb
`default_nettype wire
